/* homing_pkg.sv */
/*
 * shared constants and types of the homing and jog sequencer: method codes,
 * input function codes, positioning modes, state codes, the carried structs and
 * the method decoder. assumes a 10 MHz system clock and signed 8-bit method codes.
 */
`default_nettype none
package homing_pkg;
   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int POS_W   = 32;
   localparam int SPD_W   = 16;
   localparam int FN_W    = 4;
   localparam int IN_N    = 4;  // one, two, fast five, fast six
   localparam int FAST_LO = 2;  // index of the first fast input
   typedef logic signed [7:0] method_t;

   // -----------------------------------------------------------------
   // digital input function codes
   // -----------------------------------------------------------------
   localparam logic [FN_W-1:0] FN_POS_LIMIT = 4'h5;
   localparam logic [FN_W-1:0] FN_NEG_LIMIT = 4'h6;
   localparam logic [FN_W-1:0] FN_JOG_POS   = 4'h7;
   localparam logic [FN_W-1:0] FN_JOG_NEG   = 4'h8;
   localparam logic [FN_W-1:0] FN_REF_CAM   = 4'hA;

   // -----------------------------------------------------------------
   // enumerations
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {POS_ABS = 2'b00, POS_REL = 2'b01, POS_INF = 2'b10} pos_mode_e;
   typedef enum logic [2:0] {KIND_NONE = 3'b000, KIND_SET = 3'b001, KIND_LIMIT = 3'b010,
                             KIND_CAM = 3'b011, KIND_INDEX = 3'b100, KIND_CONT = 3'b101} kind_e;
   typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_SEARCH = 3'b001, ST_LEAVE = 3'b010,
                             ST_INDEX = 3'b011, ST_SET = 3'b100} state_e;

   // -----------------------------------------------------------------
   // carried structs
   // -----------------------------------------------------------------
   typedef struct packed {
      logic              valid;
      kind_e             kind;
      logic              dir_pos;    // start travel toward the positive end
      logic              use_index;  // finish on the encoder zero pulse
      logic              edge_pos;   // continuous homing triggers on rising cam edge
      logic              add_actual; // reference = actual position + offset
   } method_s;

   typedef struct packed {
      logic [SPD_W-1:0]        cam_search_speed;
      logic [SPD_W-1:0]        index_search_speed;
      logic [SPD_W-1:0]        homing_acceleration;
      logic signed [POS_W-1:0] reference_zero_offset;
      logic [POS_W-1:0]        homing_travel_limit;
   } homing_cfg_s;

   // -----------------------------------------------------------------
   // method decoder; codes 17..30 fold onto 1..14 without the zero pulse
   // -----------------------------------------------------------------
   function automatic method_s decode_method(input method_t m);
      method_s d;
      method_t b;
      d = '0;
      b = (m >= 8'sh11 && m <= 8'sh1E) ? method_t'(m - 8'sh10) : m;
      d.use_index = !(m >= 8'sh11 && m <= 8'sh1E);
      d.valid = 1'b1;
      if (m == 8'sh23 || m == -8'sh01 || m == -8'sh0C) begin
         d.kind = KIND_SET;
      end else if (m == -8'sh02 || m == -8'sh05) begin
         d.kind       = KIND_SET;
         d.add_actual = 1'b1;
      end else if (m == -8'sh03 || m == -8'sh04) begin
         d.kind      = KIND_CONT;
         d.dir_pos   = 1'b1;
         d.use_index = 1'b0;
         d.edge_pos  = (m == -8'sh03);
      end else if (m == -8'sh06 || m == -8'sh07 || m == 8'sh21 || m == 8'sh22) begin
         d.kind    = KIND_INDEX;
         d.dir_pos = (m == -8'sh07 || m == 8'sh22);
      end else if (m >= -8'sh0B && m <= -8'sh08) begin
         d.kind      = KIND_LIMIT;
         d.dir_pos   = (m == -8'sh08 || m == -8'sh0A);
         d.use_index = (m <= -8'sh0A);
      end else if (b == 8'sh01 || b == 8'sh02) begin
         d.kind    = KIND_LIMIT;
         d.dir_pos = (b == 8'sh02);
      end else if (b >= 8'sh03 && b <= 8'sh0E) begin
         d.kind     = KIND_CAM;
         d.dir_pos  = (b <= 8'sh04) || (b >= 8'sh07 && b <= 8'sh0A);
         d.edge_pos = ~b[0];
      end else begin
         d.valid     = 1'b0;
         d.use_index = 1'b0;
      end
      return d;
   endfunction
endpackage
`default_nettype wire

/* homing_and_jog_sequencer.sv */
/*
 * homing and jog sequencer of one servo axis: method decode, reference search,
 * zero pulse capture, travel limit, reference load and two-speed jog.
 * assumes actual position comes from same-clock encoder logic; switch, cam,
 * jog and zero pulse pins are asynchronous and are synchronised here.
 */
// Operation
// - method 35 loads reference without moving
// - homing needed only absolute without absolute encoder
// - method -5 adjusts absolute encoder zero
// - method picks signal, direction, zero pulse use
// - two speeds, acceleration and travel limit govern
// - -12 machine point, -8..-11 block approach
// - -7 positive, -6 negative incremental homing
// - -4/-3 continuous homing on cam edge
// - -2 offset only, -1 position zero
// - 1/2 limit switch then zero pulse
// - 3..14 cam edge then zero pulse
// - 17..30 as 1..14 without zero pulse
// - 33/34 first zero pulse, negative/positive
// - speed pair: cam search, zero search
// - reference position takes zero offset
// - travel beyond limit stops, flags overrun
// - cam assignable to fast inputs
// - function 5 positive, 6 negative limit
// - function 10 marks reference cam
// - jog from functions 7/8 or bus
// - one jog input moves at slow speed
// - both inputs quick, direction of first
`timescale 1ns/1ps
`default_nettype none
module homing_and_jog_sequencer (
   input  wire logic                                  CLK,
   input  wire logic                                  RST_N,
   input  wire homing_pkg::method_t                   HOMING_METHOD_SELECT,
   input  wire logic                                  HOMING_START,
   input  wire homing_pkg::homing_cfg_s               HOMING_CFG,
   input  wire homing_pkg::pos_mode_e                 POSITIONING_MODE,
   input  wire logic                                  ABS_ENCODER,
   input  wire logic signed [homing_pkg::POS_W-1:0]   ACTUAL_POSITION,
   input  wire logic                                  DIGITAL_INPUT_ONE,
   input  wire logic                                  DIGITAL_INPUT_TWO,
   input  wire logic                                  FAST_DIGITAL_INPUT_FIVE,
   input  wire logic                                  FAST_DIGITAL_INPUT_SIX,
   input  wire logic [homing_pkg::IN_N-1:0][homing_pkg::FN_W-1:0] INPUT_FUNCTION,
   input  wire logic                                  ZERO_PULSE,
   input  wire logic                                  JOG_BUS_POSITIVE,
   input  wire logic                                  JOG_BUS_NEGATIVE,
   input  wire logic [homing_pkg::SPD_W-1:0]          SLOW_JOG_SPEED,
   input  wire logic [homing_pkg::SPD_W-1:0]          QUICK_JOG_SPEED,
   output logic signed [homing_pkg::SPD_W:0]          SPEED_CMD,
   output logic [homing_pkg::SPD_W-1:0]               ACCEL_CMD,
   output logic                                       HOMING_BUSY,
   output logic                                       HOMING_DONE,
   output logic                                       OVERRUN_ERROR,
   output logic                                       METHOD_UNDEFINED,
   output logic                                       POSITION_LOAD,
   output logic signed [homing_pkg::POS_W-1:0]        POSITION_LOAD_VALUE,
   output logic                                       MOTION_PERMIT,
   output logic                                       JOG_ACTIVE
);
   localparam int PW = homing_pkg::POS_W;
   localparam int SW = homing_pkg::SPD_W;

   // -----------------------------------------------------------------
   // reset release and pin synchronisers
   // -----------------------------------------------------------------
   logic       rst_meta_reg;
   logic       rst_n;
   logic [4:0] pin_meta_reg;
   logic [4:0] pin_sync_reg;
   logic       ref_prev_reg;
   logic       zp_prev_reg;

   // reset asserts at once but releases two edges later to avoid a runt release
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // first stage is read only by the second stage
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_reg <= 5'h00;
         pin_sync_reg <= 5'h00;
      end else begin
         pin_meta_reg <= {ZERO_PULSE, FAST_DIGITAL_INPUT_SIX, FAST_DIGITAL_INPUT_FIVE,
                          DIGITAL_INPUT_TWO, DIGITAL_INPUT_ONE};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // -----------------------------------------------------------------
   // input function decode
   // -----------------------------------------------------------------
   logic [homing_pkg::IN_N-1:0] is_pos_lim;
   logic [homing_pkg::IN_N-1:0] is_neg_lim;
   logic [homing_pkg::IN_N-1:0] is_cam;
   logic [homing_pkg::IN_N-1:0] is_jog_p;
   logic [homing_pkg::IN_N-1:0] is_jog_n;

   // each input carries the role its function code names, the cam role on the fast inputs only
   for (genvar i = 0; i < homing_pkg::IN_N; i++) begin : g_role
      assign is_pos_lim[i] = pin_sync_reg[i] && INPUT_FUNCTION[i] == homing_pkg::FN_POS_LIMIT;
      assign is_neg_lim[i] = pin_sync_reg[i] && INPUT_FUNCTION[i] == homing_pkg::FN_NEG_LIMIT;
      // only the fast inputs latch the cam edge with low jitter
      assign is_cam[i]     = (i >= homing_pkg::FAST_LO) && pin_sync_reg[i]
                             && INPUT_FUNCTION[i] == homing_pkg::FN_REF_CAM;
      assign is_jog_p[i]   = pin_sync_reg[i] && INPUT_FUNCTION[i] == homing_pkg::FN_JOG_POS;
      assign is_jog_n[i]   = pin_sync_reg[i] && INPUT_FUNCTION[i] == homing_pkg::FN_JOG_NEG;
   end

   wire pos_limit = |is_pos_lim;
   wire neg_limit = |is_neg_lim;
   wire ref_cam   = |is_cam;
   wire jog_p     = (|is_jog_p) || JOG_BUS_POSITIVE;
   wire jog_n     = (|is_jog_n) || JOG_BUS_NEGATIVE;
   wire zp        = pin_sync_reg[4];

   // -----------------------------------------------------------------
   // homing state and latched settings
   // -----------------------------------------------------------------
   homing_pkg::state_e       state_reg, state_next;
   homing_pkg::method_s      meth_reg;
   homing_pkg::homing_cfg_s  cfg_reg;
   logic                     dir_pos_reg, dir_next;
   logic signed [PW-1:0]     start_pos_reg;
   logic                     done_reg, overrun_reg, undef_reg;
   logic                     first_neg_reg;

   wire homing_pkg::method_s dec  = homing_pkg::decode_method(HOMING_METHOD_SELECT);
   wire start_ok  = state_reg == homing_pkg::ST_IDLE && HOMING_START && dec.valid;
   wire start_bad = state_reg == homing_pkg::ST_IDLE && HOMING_START && !dec.valid;
   wire homing_pkg::method_s meth_sel = start_ok ? dec : meth_reg;
   wire homing_pkg::homing_cfg_s cfg_sel = start_ok ? HOMING_CFG : cfg_reg;

   // reference signal: cam for cam methods, else the limit in search direction
   wire use_cam   = meth_reg.kind == homing_pkg::KIND_CAM || meth_reg.kind == homing_pkg::KIND_CONT;
   wire ref_sig   = use_cam ? ref_cam : (meth_reg.dir_pos ? pos_limit : neg_limit);
   wire ref_rise  = ref_sig && !ref_prev_reg;
   wire ref_fall  = !ref_sig && ref_prev_reg;
   wire zp_rise   = zp && !zp_prev_reg;

   // travel since start, as a magnitude, against the limit
   wire signed [PW:0] travel = (PW+1)'(ACTUAL_POSITION) - (PW+1)'(start_pos_reg);
   wire [PW:0] travel_abs = travel[PW] ? (PW+1)'(-travel) : travel;
   wire moving    = state_reg inside {homing_pkg::ST_SEARCH, homing_pkg::ST_LEAVE, homing_pkg::ST_INDEX};
   wire overrun   = moving && travel_abs > {1'b0, cfg_reg.homing_travel_limit};

   // next state of the reference search
   always_comb begin
      state_next = state_reg;
      dir_next   = dir_pos_reg;
      unique case (state_reg)
         homing_pkg::ST_IDLE: begin
            if (start_ok) begin
               dir_next = dec.dir_pos;
               unique case (dec.kind)
                  homing_pkg::KIND_SET:   state_next = homing_pkg::ST_SET;
                  homing_pkg::KIND_INDEX: state_next = homing_pkg::ST_INDEX;
                  default:                state_next = homing_pkg::ST_SEARCH;
               endcase
            end
         end
         homing_pkg::ST_SEARCH: begin
            if (meth_reg.kind == homing_pkg::KIND_CONT) begin
               if (meth_reg.edge_pos ? ref_rise : ref_fall) begin
                  state_next = homing_pkg::ST_SET;
               end
            end else if (ref_rise) begin
               state_next = homing_pkg::ST_LEAVE;
               dir_next   = !dir_pos_reg; // reverse on the active edge
            end
         end
         homing_pkg::ST_LEAVE: begin
            if (ref_fall) begin
               state_next = meth_reg.use_index ? homing_pkg::ST_INDEX : homing_pkg::ST_SET;
            end
         end
         homing_pkg::ST_INDEX: begin
            if (zp_rise) begin
               state_next = homing_pkg::ST_SET;
            end
         end
         homing_pkg::ST_SET: state_next = homing_pkg::ST_IDLE;
         default:            state_next = homing_pkg::ST_IDLE;
      endcase
      if (overrun) begin
         state_next = homing_pkg::ST_IDLE;
      end
   end

   // state, latched method and settings
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= homing_pkg::ST_IDLE;
         meth_reg      <= '0;
         cfg_reg       <= '0;
         dir_pos_reg   <= 1'b0;
         start_pos_reg <= '0;
      end else begin
         state_reg     <= state_next;
         meth_reg      <= meth_sel;
         cfg_reg       <= cfg_sel;
         dir_pos_reg   <= dir_next;
         start_pos_reg <= start_ok ? ACTUAL_POSITION : start_pos_reg;
      end
   end

   // edge history and status flags; a valid start clears, completion, overrun or a refused start sets
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ref_prev_reg <= 1'b0;
         zp_prev_reg  <= 1'b0;
         done_reg     <= 1'b0;
         overrun_reg  <= 1'b0;
         undef_reg    <= 1'b0;
      end else begin
         ref_prev_reg <= ref_sig;
         zp_prev_reg  <= zp;
         done_reg     <= (state_reg == homing_pkg::ST_SET) || (done_reg && !start_ok);
         overrun_reg  <= overrun || (overrun_reg && !start_ok);
         undef_reg    <= start_bad || (undef_reg && !start_ok);
      end
   end

   // -----------------------------------------------------------------
   // reference load
   // -----------------------------------------------------------------
   logic                 load_reg;
   logic signed [PW-1:0] load_value_reg;
   // the offset names where the reference sits on the axis
   wire signed [PW-1:0] load_value_next = meth_reg.add_actual
                        ? PW'(ACTUAL_POSITION + cfg_reg.reference_zero_offset)
                        : cfg_reg.reference_zero_offset;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         load_reg       <= 1'b0;
         load_value_reg <= '0;
      end else begin
         load_reg       <= state_reg == homing_pkg::ST_SET;
         load_value_reg <= (state_reg == homing_pkg::ST_SET) ? load_value_next : load_value_reg;
      end
   end

   // -----------------------------------------------------------------
   // jog and speed command
   // -----------------------------------------------------------------
   // remember which jog input came first while only one is held
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         first_neg_reg <= 1'b0;
      end else begin
         first_neg_reg <= (jog_p ^ jog_n) ? jog_n : first_neg_reg;
      end
   end

   wire jog_both  = jog_p && jog_n;
   wire jog_any   = jog_p || jog_n;
   wire [SW-1:0] jog_mag = jog_both ? QUICK_JOG_SPEED : SLOW_JOG_SPEED;
   wire jog_neg_dir = jog_both ? first_neg_reg : jog_n;
   wire move_next = state_next inside {homing_pkg::ST_SEARCH, homing_pkg::ST_LEAVE, homing_pkg::ST_INDEX};
   // search uses the cam speed, leaving and zero search the slower one
   wire [SW-1:0] home_mag = (state_next == homing_pkg::ST_SEARCH)
                            ? cfg_sel.cam_search_speed : cfg_sel.index_search_speed;
   wire jog_next  = state_next == homing_pkg::ST_IDLE && state_reg == homing_pkg::ST_IDLE && jog_any;
   wire [SW-1:0] mag_next = move_next ? home_mag : (jog_next ? jog_mag : '0);
   wire neg_next  = move_next ? !dir_next : jog_neg_dir;
   wire signed [SW:0] speed_next = neg_next ? -(SW+1)'(mag_next) : (SW+1)'(mag_next);
   // absolute moves wait for a reference unless the encoder is absolute
   wire permit_next = POSITIONING_MODE != homing_pkg::POS_ABS || ABS_ENCODER || done_reg;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         SPEED_CMD     <= '0;
         ACCEL_CMD     <= '0;
         JOG_ACTIVE    <= 1'b0;
         MOTION_PERMIT <= 1'b0;
      end else begin
         SPEED_CMD     <= speed_next;
         ACCEL_CMD     <= move_next ? cfg_sel.homing_acceleration : ACCEL_CMD;
         JOG_ACTIVE    <= jog_next;
         MOTION_PERMIT <= permit_next;
      end
   end

   assign HOMING_BUSY         = state_reg != homing_pkg::ST_IDLE;
   assign HOMING_DONE         = done_reg;
   assign OVERRUN_ERROR       = overrun_reg;
   assign METHOD_UNDEFINED    = undef_reg;
   assign POSITION_LOAD       = load_reg;
   assign POSITION_LOAD_VALUE = load_value_reg;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n);

   wire [SW-1:0] speed_mag = SPEED_CMD[SW] ? SW'(-SPEED_CMD) : SW'(SPEED_CMD);

   sequence left_then_both_s;
      (state_reg == homing_pkg::ST_IDLE && jog_n && !jog_p)
      ##1 (state_reg == homing_pkg::ST_IDLE && jog_both)[*2];
   endsequence

   sequence set_then_load_s;
      state_reg == homing_pkg::ST_SET ##1 POSITION_LOAD;
   endsequence

   undefined_no_start_a: assert property (start_bad |=> !HOMING_BUSY && METHOD_UNDEFINED)
      else $error("undefined method started homing");
   set_now_load_a: assert property ((start_ok && dec.kind == homing_pkg::KIND_SET) |=> set_then_load_s
                                    and (SPEED_CMD == '0)[*2])
      else $error("set-now method moved or did not load");
   load_offset_a: assert property ((state_reg == homing_pkg::ST_SET && !meth_reg.add_actual)
                                   |=> POSITION_LOAD_VALUE == $past(cfg_reg.reference_zero_offset))
      else $error("reference load value is not the zero offset");
   relative_permit_a: assert property (POSITIONING_MODE == homing_pkg::POS_REL |=> MOTION_PERMIT)
      else $error("relative positioning held back by homing");
   overrun_stop_a: assert property (overrun |=> SPEED_CMD == '0 && OVERRUN_ERROR && !HOMING_BUSY)
      else $error("overrun did not stop the axis");
   search_speed_a: assert property (state_reg == homing_pkg::ST_SEARCH |-> speed_mag == cfg_reg.cam_search_speed)
      else $error("cam search not at the first homing speed");
   index_speed_a: assert property (state_reg == homing_pkg::ST_INDEX |-> speed_mag == cfg_reg.index_search_speed)
      else $error("zero search not at the second homing speed");
   index_finish_a: assert property ((state_reg == homing_pkg::ST_INDEX && zp_rise && !overrun)
                                    |=> state_reg == homing_pkg::ST_SET ##1 HOMING_DONE)
      else $error("zero pulse did not finish homing");
   quick_left_a: assert property (left_then_both_s |=> SPEED_CMD == -(SW+1)'($past(QUICK_JOG_SPEED)))
      else $error("quick jog left not taken");
   slow_jog_a: assert property ((state_reg == homing_pkg::ST_IDLE && !HOMING_START && jog_p && !jog_n)
                                |=> SPEED_CMD == (SW+1)'($past(SLOW_JOG_SPEED)))
      else $error("single jog input not at slow speed");
endmodule
`default_nettype wire

/* axis_motor_model.sv */
/*
 * motor, encoder and switch model of one axis: integrates the speed command
 * into position and derives positive limit, reference cam and zero pulse.
 * assumes the sequencer's clock and signed speed units, no inertia.
 */
`timescale 1ns/1ps
`default_nettype none
module axis_motor_model (
   input  wire logic                              clk,
   input  wire logic                              rst_n,
   input  wire logic signed [homing_pkg::SPD_W:0] speed,
   output logic signed [homing_pkg::POS_W-1:0]    pos,
   output logic                                   pos_limit,
   output logic                                   cam,
   output logic                                   zero_pulse
);
   // position steps by the command each clock, so overshoot equals sync delay
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pos <= '0;
      else pos <= pos + speed;
   end
   // limit at 2000, cam over 1000..1500, zero pulse once per 4096 counts
   assign pos_limit  = pos >= 32'sh000007D0;
   assign cam        = pos >= 32'sh000003E8 && pos <= 32'sh000005DC;
   assign zero_pulse = pos[11:8] == 4'h0;
endmodule
`default_nettype wire

/* homing_and_jog_sequencer_tb.sv */
/*
 * bench of the homing and jog sequencer: method table, limit, cam and zero
 * pulse runs, overrun, jog, permit and reset, against the motor model.
 * assumes the package, the sequencer and the model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module homing_and_jog_sequencer_tb;
   typedef struct packed {
      homing_pkg::method_t code;
      logic [1:0]          kind; // 0 refused, 1 offset, 2 actual plus offset
      logic signed [16:0]  sp;   // speed in the first busy cycle
      logic                rev;  // reversal at zero search speed expected
   } row_s;
   localparam logic [15:0] CAM = 16'h0014, IDX = 16'h0008, ACC = 16'h0123;
   localparam logic [15:0] SLOW = 16'h000A, QUICK = 16'h0064;
   localparam logic signed [31:0] OFS = 32'sh00001234;
   logic                    clk, rst_n, start, one, two, abs_enc, saw_rev, bus_p;
   logic                    pos_lim, cam, zp, busy, done, ovr, undef, load, permit, jog;
   homing_pkg::method_t     method;
   homing_pkg::homing_cfg_s cfg;
   homing_pkg::pos_mode_e   mode;
   logic signed [31:0]      pos, load_val;
   logic signed [16:0]      speed;
   logic [15:0]             accel;
   int                      mismatches, checks, cycles;
   // refused codes follow a valid start so the sticky flag is fresh each time
   row_s rows [17] = '{
      '{8'sh23, 2'd1, 17'sh00000, 1'b0}, '{8'sh00, 2'd0, 17'sh00000, 1'b0},
      '{-8'sh01, 2'd1, 17'sh00000, 1'b0}, '{8'sh0F, 2'd0, 17'sh00000, 1'b0},
      '{-8'sh0C, 2'd1, 17'sh00000, 1'b0}, '{8'sh10, 2'd0, 17'sh00000, 1'b0},
      '{8'sh03, 2'd1, 17'sh00014, 1'b1}, '{8'sh1F, 2'd0, 17'sh00000, 1'b0},
      '{8'sh02, 2'd1, 17'sh00014, 1'b1}, '{8'sh20, 2'd0, 17'sh00000, 1'b0},
      '{-8'sh02, 2'd2, 17'sh00000, 1'b0}, '{8'sh24, 2'd0, 17'sh00000, 1'b0},
      '{8'sh12, 2'd1, 17'sh00014, 1'b1}, '{-8'sh0D, 2'd0, 17'sh00000, 1'b0},
      '{-8'sh05, 2'd2, 17'sh00000, 1'b0}, '{8'sh22, 2'd1, 17'sh00008, 1'b0},
      '{-8'sh07, 2'd1, 17'sh00008, 1'b0}};
   homing_and_jog_sequencer i_dut (.CLK(clk), .RST_N(rst_n), .HOMING_METHOD_SELECT(method),
      .HOMING_START(start), .HOMING_CFG(cfg), .POSITIONING_MODE(mode), .ABS_ENCODER(abs_enc),
      .ACTUAL_POSITION(pos), .DIGITAL_INPUT_ONE(one), .DIGITAL_INPUT_TWO(two),
      .FAST_DIGITAL_INPUT_FIVE(pos_lim), .FAST_DIGITAL_INPUT_SIX(cam), .ZERO_PULSE(zp),
      .INPUT_FUNCTION({homing_pkg::FN_REF_CAM, homing_pkg::FN_POS_LIMIT, homing_pkg::FN_JOG_NEG,
                       homing_pkg::FN_JOG_POS}), .JOG_BUS_POSITIVE(bus_p), .JOG_BUS_NEGATIVE(1'b0),
      .SLOW_JOG_SPEED(SLOW), .QUICK_JOG_SPEED(QUICK), .SPEED_CMD(speed), .ACCEL_CMD(accel),
      .HOMING_BUSY(busy), .HOMING_DONE(done), .OVERRUN_ERROR(ovr), .METHOD_UNDEFINED(undef),
      .POSITION_LOAD(load), .POSITION_LOAD_VALUE(load_val), .MOTION_PERMIT(permit), .JOG_ACTIVE(jog));
   axis_motor_model i_motor (.clk(clk), .rst_n(rst_n), .speed(speed), .pos(pos),
      .pos_limit(pos_lim), .cam(cam), .zero_pulse(zp));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // cycle ceiling cuts a hang short; the flag records a reversed search
   always @(posedge clk) begin
      cycles++;
      if (speed === -17'sh00008) saw_rev = 1'b1;
      if (cycles == 6000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // inputs always move 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic home(input homing_pkg::method_t m);
      method = m;
      start = 1'b1;
      saw_rev = 1'b0;
      tick(1);
      start = 1'b0;
   endtask
   // five cycles cover the two-stage pin sync and the speed register
   task automatic jog_step(input logic p, input logic q, input logic signed [16:0] want);
      one = p;
      two = q;
      tick(5);
      chk(speed, want);
      chk(jog, want != 17'sh00000);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      logic signed [31:0] exp;
      int n;
      {rst_n, start, one, two, abs_enc, saw_rev, bus_p} = '0;
      method = 8'sh00;
      mode = homing_pkg::POS_ABS;
      cfg = '{CAM, IDX, ACC, OFS, 32'h00100000};
      tick(8);
      rst_n = 1'b1;
      tick(6);
      chk(permit, 1'b0);
      mode = homing_pkg::POS_REL;
      tick(2);
      chk(permit, 1'b1);
      mode = homing_pkg::POS_INF;
      tick(2);
      chk(permit, 1'b1);
      mode = homing_pkg::POS_ABS;
      abs_enc = 1'b1;
      tick(2);
      chk(permit, 1'b1);
      abs_enc = 1'b0;
      foreach (rows[i]) begin
         exp = OFS + (rows[i].kind == 2'd2 ? pos : 32'sh00000000);
         home(rows[i].code);
         if (rows[i].kind == 2'd0) begin
            chk(undef, 1'b1);
            chk(busy, 1'b0);
         end else begin
            chk(speed, rows[i].sp);
            if (rows[i].sp != 17'sh00000) chk(accel, ACC);
            for (n = 0; n < 2000 && load !== 1'b1; n++) tick(1);
            chk(load, 1'b1);
            chk(load_val, exp);
            chk(done, 1'b1);
            chk(saw_rev, rows[i].rev);
         end
         tick(1);
      end
      chk(permit, 1'b1);
      // 100 counts at 8 a cycle: still moving after 8 cycles, stopped soon after
      cfg.homing_travel_limit = 32'h00000064;
      home(8'sh22);
      tick(8);
      chk(busy, 1'b1);
      for (n = 0; n < 20 && busy !== 1'b0; n++) tick(1);
      chk(busy, 1'b0);
      chk(ovr, 1'b1);
      chk(done, 1'b0);
      chk(speed, 17'sh00000);
      jog_step(1'b1, 1'b0, 17'sh0000A);
      jog_step(1'b1, 1'b1, 17'sh00064);
      jog_step(1'b0, 1'b0, 17'sh00000);
      jog_step(1'b0, 1'b1, -17'sh0000A);
      jog_step(1'b1, 1'b1, -17'sh00064);
      jog_step(1'b0, 1'b0, 17'sh00000);
      bus_p = 1'b1;
      jog_step(1'b0, 1'b0, 17'sh0000A);
      bus_p = 1'b0;
      // reset in the middle of a run must drop everything at once
      cfg.homing_travel_limit = 32'h00100000;
      home(8'sh22);
      tick(3);
      rst_n = 1'b0;
      tick(1);
      chk(busy, 1'b0);
      chk(speed, 17'sh00000);
      chk(permit, 1'b0);
      rst_n = 1'b1;
      tick(4);
      // continuous homing from rest, first start after the release
      home(-8'sh03);
      chk(speed, 17'sh00014);
      for (n = 0; n < 200 && load !== 1'b1; n++) tick(1);
      chk(load_val, OFS);
      conclude();
   end
endmodule
`default_nettype wire
